// file: hdl/tpw_pkg.sv
// constants, register map and field layout of the timer2 pwm block
package tpw_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int CNT_W = 10;
    localparam int PS_W = 8;
    localparam int SEL_W = 3;
    // word index of each register; byte address is four times this
    localparam logic [ADDR_W-1:0] IDX_COUNT_LOW = 4'h9;
    localparam logic [ADDR_W-1:0] IDX_CTRL_ONE = 4'hA;
    localparam logic [ADDR_W-1:0] IDX_CTRL_TWO = 4'hB;
    localparam logic [ADDR_W-1:0] IDX_DUTY_LOW = 4'hC;
    localparam logic [ADDR_W-1:0] IDX_HIGH_BITS = 4'hD;
    localparam logic [ADDR_W-1:0] IDX_STATUS = 4'hE;
    localparam logic [ADDR_W-1:0] IDX_PS_VALUE = 4'hF;
    // control one fields
    localparam int B_COUNT_EN = 0;
    localparam int B_RELOAD_SEL = 1;
    localparam int B_ONE_SHOT = 2;
    localparam int B_ACTIVE_LOW = 6;
    localparam int B_PIN_EN = 7;
    // control two fields
    localparam int B_PS_DIS_N = 3;
    localparam int B_EDGE_SEL = 4;
    localparam int B_CLK_SRC = 5;
    // shared high bits fields and the status underflow bit
    localparam int B_RELOAD_HI = 6;
    localparam int B_DUTY_HI = 2;
    localparam int B_UNDERFLOW = 0;
    localparam logic [7:0] CTRL_ONE_RST = 8'h00;
    localparam logic [7:0] CTRL_TWO_RST = 8'h3F;
    localparam logic [7:0] HIGH_BITS_RST = 8'h00;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_FULL = 10'h3FF;
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    localparam logic [CNT_W-1:0] CNT_RST = 10'h3FF;
    localparam logic [PS_W-1:0] PS_ONE = 8'h01;
    localparam logic [PS_W-1:0] PS_RST = 8'hFF;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK = 2'b01
    } tpw_bus_t;
endpackage : tpw_pkg

// file: hdl/tpw_tick_gen.sv
// count tick source: clock choice, external edge detect and prescaler
module tpw_tick_gen
    import tpw_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ext_clk_i,
    input wire logic clk_src_i,
    input wire logic edge_sel_i,
    input wire logic ps_dis_n_i,
    input wire logic [SEL_W-1:0] ratio_i,
    output logic tick_o,
    output logic [PS_W-1:0] ps_value_o
);
    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic [PS_W-1:0] ps_q;
    logic [PS_W-1:0] ps_d;
    logic [PS_W-1:0] ps_mask;
    logic raw_tick;
    logic ps_tick;

    // two-flop synchroniser, third flop only feeds the edge detector
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= ext_clk_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    wire rise = sync2_q & ~sync3_q;
    wire fall = ~sync2_q & sync3_q;
    wire ext_edge = edge_sel_i ? fall : rise;
    assign raw_tick = clk_src_i ? ext_edge : 1'b1;

    // divide by 2^(ratio+1): tick when the low ratio+1 bits wrap
    assign ps_mask = PS_W'((16'h0002 << ratio_i) - 16'h0001);
    assign ps_d = ps_q - PS_ONE;
    assign ps_tick = raw_tick && ((ps_q & ps_mask) == '0);
    assign tick_o = ps_dis_n_i ? raw_tick : ps_tick;
    assign ps_value_o = ps_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ps_q <= PS_RST;
        end else if (ps_dis_n_i) begin
            ps_q <= PS_RST;
        end else if (raw_tick) begin
            ps_q <= ps_d;
        end
    end
endmodule : tpw_tick_gen

// file: hdl/tpw_timer.sv
// timer2 with prescaler, pwm output and avalon-mm register slave
module tpw_timer
    import tpw_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RESET_I,
    input wire logic [tpw_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [tpw_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [tpw_pkg::DATA_W-1:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic EXT_CLOCK_PIN_I,
    input wire logic GPIO_OUT_I,
    input wire logic GPIO_OE_N_I,
    output logic PWM_PORT_PIN_O,
    output logic PWM_PORT_PIN_OE_N_O,
    output logic UNDERFLOW_O
);
    import tpw_pkg::*;

    tpw_bus_t bus_q;
    tpw_bus_t bus_d;
    logic [7:0] ctrl_one_q;
    logic [7:0] ctrl_two_q;
    logic [7:0] high_q;
    logic [7:0] duty_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] reload_q;
    logic stopped_q;
    logic uflow_q;
    logic sticky_q;
    logic pwm_q;
    logic [DATA_W-1:0] rdata_q;
    logic tick;
    logic [PS_W-1:0] ps_value;

    // every access takes one wait cycle, answered in BUS_ACK
    wire req = AVS_READ_I | AVS_WRITE_I;
    wire acc = (bus_q == BUS_ACK);
    assign bus_d = (bus_q == BUS_IDLE && req) ? BUS_ACK : BUS_IDLE;
    assign AVS_WAITREQUEST_O = req & ~acc;
    assign AVS_READDATA_O = rdata_q;

    wire wr = acc & AVS_WRITE_I & AVS_BYTEENABLE_I[0];
    // read data is captured in the wait cycle so it stands while waitrequest is low
    wire rd = (bus_q == BUS_IDLE) & AVS_READ_I;
    wire wr_count = wr && AVS_ADDRESS_I == IDX_COUNT_LOW;
    wire wr_one = wr && AVS_ADDRESS_I == IDX_CTRL_ONE;
    wire wr_two = wr && AVS_ADDRESS_I == IDX_CTRL_TWO;
    wire wr_duty = wr && AVS_ADDRESS_I == IDX_DUTY_LOW;
    wire wr_high = wr && AVS_ADDRESS_I == IDX_HIGH_BITS;
    wire wr_stat = wr && AVS_ADDRESS_I == IDX_STATUS;
    wire [7:0] wbyte = AVS_WRITEDATA_I[7:0];

    wire count_en = ctrl_one_q[B_COUNT_EN];
    wire reload_sel = ctrl_one_q[B_RELOAD_SEL];
    wire one_shot = ctrl_one_q[B_ONE_SHOT];
    wire active_low = ctrl_one_q[B_ACTIVE_LOW];
    wire pin_en = ctrl_one_q[B_PIN_EN];
    wire [CNT_W-1:0] reload_new = {high_q[B_RELOAD_HI+1:B_RELOAD_HI], wbyte};
    wire [CNT_W-1:0] duty = {high_q[B_DUTY_HI+1:B_DUTY_HI], duty_q};

    // read mux; the duty byte is write-only and reads as zero
    logic [7:0] rmux;
    always_comb begin
        case (AVS_ADDRESS_I)
            IDX_COUNT_LOW: rmux = cnt_q[7:0];
            IDX_CTRL_ONE: rmux = ctrl_one_q;
            IDX_CTRL_TWO: rmux = ctrl_two_q;
            IDX_HIGH_BITS: rmux = high_q;
            IDX_STATUS: rmux = {7'h00, sticky_q};
            IDX_PS_VALUE: rmux = ps_value;
            default: rmux = 8'h00;
        endcase
    end

    tpw_tick_gen u_tick (
        .clk_i(CLK_SYS_I),
        .rst_i(RESET_I),
        .ext_clk_i(EXT_CLOCK_PIN_I),
        .clk_src_i(ctrl_two_q[B_CLK_SRC]),
        .edge_sel_i(ctrl_two_q[B_EDGE_SEL]),
        .ps_dis_n_i(ctrl_two_q[B_PS_DIS_N]),
        .ratio_i(ctrl_two_q[SEL_W-1:0]),
        .tick_o(tick),
        .ps_value_o(ps_value)
    );

    wire step = count_en & tick & ~stopped_q;
    wire at_zero = (cnt_q == CNT_ZERO);
    wire uflow = step & at_zero;
    always_comb begin
        cnt_d = cnt_q - 10'h001;
        if (at_zero) begin
            cnt_d = reload_sel ? reload_q : CNT_FULL;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            bus_q <= BUS_IDLE;
            rdata_q <= '0;
        end else begin
            bus_q <= bus_d;
            if (rd) begin
                rdata_q <= {24'h000000, rmux};
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            ctrl_one_q <= CTRL_ONE_RST;
            ctrl_two_q <= CTRL_TWO_RST;
            high_q <= HIGH_BITS_RST;
            duty_q <= DUTY_RST;
        end else begin
            if (wr_one) ctrl_one_q <= wbyte;
            if (wr_two) ctrl_two_q <= wbyte;
            if (wr_high) high_q <= wbyte;
            if (wr_duty) duty_q <= wbyte;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            cnt_q <= CNT_RST;
            reload_q <= CNT_RST;
            stopped_q <= 1'b0;
        end else if (wr_count) begin
            cnt_q <= reload_new;
            reload_q <= reload_new;
            stopped_q <= 1'b0;
        end else if (step) begin
            if (at_zero && one_shot) begin
                stopped_q <= 1'b1;
            end else begin
                cnt_q <= cnt_d;
            end
        end
    end

    // underflow pulse and sticky flag; a new underflow beats a clear
    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            uflow_q <= 1'b0;
            sticky_q <= 1'b0;
        end else begin
            uflow_q <= uflow;
            if (uflow) begin
                sticky_q <= 1'b1;
            end else if (wr_stat && wbyte[B_UNDERFLOW]) begin
                sticky_q <= 1'b0;
            end
        end
    end

    // period from reload value or full count, active while count_en and count at or below duty
    wire pwm_act = count_en & (cnt_q <= duty);
    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            pwm_q <= 1'b0;
        end else begin
            pwm_q <= pwm_act ^ active_low;
        end
    end

    assign PWM_PORT_PIN_O = pin_en ? pwm_q : GPIO_OUT_I;
    assign PWM_PORT_PIN_OE_N_O = pin_en ? 1'b0 : GPIO_OE_N_I;
    assign UNDERFLOW_O = uflow_q;

    a_bus_one_wait: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (req && bus_q == BUS_IDLE) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
        else $error("bus answer not after one wait");
    a_count_write_load: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        wr_count |=> (cnt_q == $past(reload_new) && reload_q == $past(reload_new)))
        else $error("counter write not loaded");
    a_halt_when_off: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (!count_en && !wr_count) |=> $stable(cnt_q))
        else $error("counter moved while disabled");
    a_reload_full: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (step && at_zero && !one_shot && !reload_sel && !wr_count) |=> cnt_q == CNT_FULL)
        else $error("no reload to full");
    a_reload_value: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (step && at_zero && !one_shot && reload_sel && !wr_count) |=> cnt_q == $past(reload_q))
        else $error("no reload of programmed value");
    a_one_shot_stop: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (step && at_zero && one_shot && !wr_count) |=> (stopped_q && cnt_q == CNT_ZERO))
        else $error("one-shot did not stop");
    a_count_down: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (step && !at_zero && !wr_count) |=> cnt_q == $past(cnt_q) - 10'h001)
        else $error("counter did not decrement");
    a_pwm_level: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        1'b1 |=> pwm_q == (($past(count_en) && $past(cnt_q) <= $past(duty)) ^ $past(active_low)))
        else $error("pwm level wrong");
    a_pin_takeover: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        pin_en |-> (!PWM_PORT_PIN_OE_N_O && PWM_PORT_PIN_O == pwm_q))
        else $error("pin not driven by pwm");
    a_uflow_pulse: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        uflow |=> (UNDERFLOW_O && sticky_q))
        else $error("underflow not flagged");
endmodule : tpw_timer

// file: verif/tb_top.sv
// self-checking bench for the timer2 pwm block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tpw_pkg::*;
    typedef struct packed {
        logic w;
        logic [3:0] a;
        logic [7:0] d;
        logic [3:0] b;
        logic [7:0] e;
    } tpw_row_t;
    logic clk, rst, rd, wr, gpo, gpoe_n, wrq, ext, pin, pin_oe_n, uf, lvl;
    logic [3:0] addr, be;
    logic [31:0] wdat, rdat;
    logic [7:0] q, q2;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;
    int g, hi;
    tpw_row_t rows[12];
    tpw_timer dut (.CLK_SYS_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat),
        .AVS_WAITREQUEST_O(wrq), .EXT_CLOCK_PIN_I(ext), .GPIO_OUT_I(gpo), .GPIO_OE_N_I(gpoe_n),
        .PWM_PORT_PIN_O(pin), .PWM_PORT_PIN_OE_N_O(pin_oe_n), .UNDERFLOW_O(uf));
    tpw_far_end far (.clk_i(clk), .pin_i(pin), .pin_oe_n_i(pin_oe_n), .ext_clk_o(ext),
        .pin_level_o(lvl));
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] v);
        comparisons++;
        if (v !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, v);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wdat <= {24'h0, d};
        be <= b;
        rd <= ~w;
        wr <= w;
        // waitrequest and read data are taken as they stand at the same rising edge
        do begin
            @(posedge clk);
            n++;
        end while (wrq !== 1'b0 && n < 50);
        q = rdat[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
        if (n == 50) err_total++;
    endtask : bus
    task automatic w8(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask : w8
    task automatic r8(input logic [3:0] a);
        bus(1'b0, a, 8'h00, 4'h1);
    endtask : r8
    // cycles until the next underflow pulse
    task automatic wuf();
        g = 0;
        do begin
            @(negedge clk);
            g++;
        end while (uf !== 1'b1 && g < 3000);
    endtask : wuf
    task automatic duty_cnt();
        hi = 0;
        repeat (20) @(negedge clk);
        repeat (100) begin
            @(negedge clk);
            hi += int'(lvl === 1'b1);
        end
    endtask : duty_cnt
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        rst = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        addr = 4'h0;
        wdat = 32'h0;
        be = 4'h0;
        gpo = 1'b0;
        gpoe_n = 1'b1;
        rows = '{'{1'b0, 4'h9, 8'h00, 4'h1, 8'hFF}, '{1'b0, 4'hA, 8'h00, 4'h1, 8'h00},
            '{1'b0, 4'hB, 8'h00, 4'h1, 8'h3F}, '{1'b0, 4'hD, 8'h00, 4'h1, 8'h00},
            '{1'b0, 4'hF, 8'h00, 4'h1, 8'hFF}, '{1'b0, 4'h3, 8'h00, 4'h1, 8'h00},
            '{1'b1, 4'hC, 8'h55, 4'h1, 8'h00}, '{1'b1, 4'h3, 8'hAA, 4'h1, 8'h00},
            '{1'b1, 4'hA, 8'hC6, 4'h0, 8'h00}, '{1'b1, 4'hA, 8'h46, 4'h1, 8'h46},
            '{1'b1, 4'hB, 8'h08, 4'h1, 8'h08}, '{1'b1, 4'h9, 8'h5A, 4'h1, 8'h5A}};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) begin
            if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d, rows[i].b);
            r8(rows[i].a);
            chk("register", 16'(rows[i].e), 16'(q));
        end
        $display("registers done");
        w8(4'hA, 8'h00);
        w8(4'h9, 8'h05);
        w8(4'hA, 8'h05);
        repeat (30) @(posedge clk);
        r8(4'h9);
        chk("one-shot", 16'h0, 16'(q));
        w8(4'hA, 8'h00);
        w8(4'h9, 8'h03);
        w8(4'hA, 8'h01);
        wuf();
        w8(4'hA, 8'h00);
        r8(4'h9);
        q2 = q;
        chk("wrap full", 16'h1, 16'(q >= 8'hE0));
        r8(4'h9);
        chk("halt", 16'(q2), 16'(q));
        r8(4'hE);
        chk("flag", 16'h1, 16'(q));
        w8(4'hE, 8'h01);
        r8(4'hE);
        chk("flag clear", 16'h0, 16'(q));
        $display("continuous done");
        w8(4'hD, 8'h40);
        w8(4'h9, 8'h80);
        w8(4'hA, 8'h03);
        wuf();
        w8(4'hA, 8'h00);
        r8(4'h9);
        chk("reload", 16'h1, 16'(q <= 8'h80 && q >= 8'h70));
        w8(4'hD, 8'h00);
        w8(4'h9, 8'h09);
        w8(4'hA, 8'h03);
        for (int r = 0; r <= 8; r++) begin
            w8(4'hB, 8'(r) | 8'h08);
            w8(4'hB, (r == 8) ? 8'h08 : 8'(r));
            wuf();
            wuf();
            wuf();
            chk("divide", (r == 8) ? 16'd10 : 16'(10 << (r + 1)), 16'(g));
        end
        $display("prescaler done");
        w8(4'hB, 8'h08);
        w8(4'hC, 8'h02);
        w8(4'hA, 8'h83);
        duty_cnt();
        chk("active high", 16'h001E, 16'(hi));
        chk("pin drive", 16'h0, 16'(pin_oe_n));
        w8(4'hA, 8'hC3);
        duty_cnt();
        chk("active low", 16'h0046, 16'(hi));
        w8(4'hD, 8'h04);
        duty_cnt();
        chk("duty high", 16'h0000, 16'(hi));
        w8(4'hA, 8'h43);
        gpo <= 1'b1;
        gpoe_n <= 1'b0;
        repeat (3) @(negedge clk);
        chk("gpio", 16'h1, 16'(lvl));
        @(posedge clk);
        gpoe_n <= 1'b1;
        repeat (3) @(negedge clk);
        chk("gpio off", 16'h1, 16'(pin_oe_n));
        $display("pwm done");
        for (int k = 0; k < 2; k++) begin
            w8(4'hA, 8'h00);
            w8(4'hB, k ? 8'h28 : 8'h38);
            w8(4'h9, 8'h20);
            w8(4'hA, 8'h01);
            far.burst(3, 4);
            repeat (8) @(posedge clk);
            r8(4'h9);
            chk("edges", 16'h1F, 16'(q));
        end
        $display("external done");
        w8(4'hB, 8'h08);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        r8(4'hA);
        chk("reset ctrl", 16'h0, 16'(q));
        r8(4'h9);
        chk("reset count", 16'hFF, 16'(q));
        $display("reset done");
        test_done();
    end
endmodule : tb_top

// file: verif/tpw_far_end.sv
// far-side model: external count clock source and pwm pin load
module tpw_far_end (
    input wire logic clk_i,
    input wire logic pin_i,
    input wire logic pin_oe_n_i,
    output logic ext_clk_o,
    output logic pin_level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // released pin is pulled up
    assign pin_level_o = pin_oe_n_i ? 1'b1 : pin_i;
    initial ext_clk_o = 1'b0;
    // clock stands still between bursts
    task automatic burst(input int steps, input int half);
        for (int i = 0; i < steps; i++) begin
            repeat (half) @(posedge clk_i);
            ext_clk_o <= ~ext_clk_o;
        end
    endtask : burst
endmodule : tpw_far_end
